// [hdl/dcr_pkg.sv]
// constants, types and field layout of the decoder control register bank
`default_nettype none
package dcr_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [3:0] VERSATILE_PIN_CONFIG_IDX = 4'hD;
  localparam logic [3:0] MOTOR_SPEED_FEATURE_CTRL_IDX = 4'hE;
  localparam logic [3:0] SUBCODE_BANK_SELECT_IDX = 4'hF;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_W = 8;
  localparam int REG_W = 4;

  // ==========================================================
  // reset values
  localparam logic [3:0] VERSATILE_PIN_CONFIG_RST = 4'hF;
  localparam logic [3:0] MOTOR_SPEED_FEATURE_CTRL_RST = 4'h4;
  localparam logic [3:0] SUBCODE_BANK_SELECT_RST = 4'h0;
  localparam logic [3:0] FOUR_LINE_MOTOR_CODE = 4'h0;
  // pin flops under reset: both pins driven, both high
  localparam logic [1:0] PIN_OUT_RST = 2'b11;
  localparam logic [1:0] PIN_OE_RST = 2'b00;

  // ==========================================================
  // field positions
  localparam int PIN_FOUR_LSB = 0;
  localparam int PIN_FIVE_LSB = 2;
  localparam int BRAKE_SIX_BIT = 0;
  localparam int LOCK_DISC_BIT = 1;
  localparam int AUDIO_FEAT_BIT = 2;
  localparam int QUAD_SPEED_BIT = 3;
  localparam int BANK_SEL_LSB = 0;
  localparam int SUBCODE_ON_BIT = 2;
  localparam int SUBCODE_THREE_BIT = 3;

  // ==========================================================
  // versatile pin function and shadow bank codes
  typedef enum logic [1:0] {
    PIN_OFF = 2'b00,
    PIN_SIGNAL = 2'b01,
    PIN_LOW = 2'b10,
    PIN_HIGH = 2'b11
  } dcr_pin_mode_t;

  typedef enum logic [1:0] {
    BANK_MAIN = 2'b00,
    BANK_ONE = 2'b01,
    BANK_TWO = 2'b10,
    BANK_THREE = 2'b11
  } dcr_bank_t;

endpackage
`default_nettype wire

// [hdl/dcr_regs.sv]
// decoder control register bank: versatile pins, motor features, subcode and banks
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module dcr_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dcr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // signals routed to the versatile pins
  input wire logic motorLineA,
  input wire logic motorLineB,
  input wire logic subcodeStreamPin,
  input wire logic deemphasisPin,
  output logic [1:0] versatilePinOut,
  output logic [1:0] versatilePinOe,
  output logic deemphasisBypass,
  // decoder controls
  output logic brakeSixPct,
  output logic lockToDisc,
  output logic audioFeatures,
  output logic quadSpeed,
  output logic subcodeOn,
  output logic subcodeThreeWire,
  output logic [1:0] shadowBankSel,
  // shadow bank write port
  output logic shadowWrite,
  output logic [3:0] shadowIndex,
  output logic [3:0] shadowData
);
  import dcr_pkg::*;

  // ==========================================================
  // overview
  // three four-bit control words behind a small apb slave
  // byte address is the register index times four; upper bits must be zero
  // one wait state per access: pready comes in the second access cycle
  // pready, prdata and pslverr stand for one cycle only
  // a write replaces all four bits of its target; no partial updates
  // nonzero bank field steers every other aligned in-range address to the shadow port
  // the bank word itself stays reachable, so software can always get back
  // unmapped or misaligned addresses answer pslverr and change nothing
  // shadow contents live outside this block and read back as zero
  // controls change at the commit edge; pin outputs trail by one more flop
  // limitation: async pin inputs add two cycles before they reach a pin
  // trade-off: read-back costs a small mux but lets software verify setups

  // ==========================================================
  // register state
  logic [REG_W-1:0] pinCfg_reg;
  logic [REG_W-1:0] pinCfg_next;
  logic [REG_W-1:0] motorCtrl_reg;
  logic [REG_W-1:0] motorCtrl_next;
  logic [REG_W-1:0] bankCfg_reg;
  logic [REG_W-1:0] bankCfg_next;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  // ==========================================================
  // pin input synchronisers
  logic subcodeMeta_reg;
  logic subcodeSync_reg;
  logic deemphMeta_reg;
  logic deemphSync_reg;

  // two stages each; only the second stage is read by logic
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      subcodeMeta_reg <= 1'b0;
      subcodeSync_reg <= 1'b0;
      deemphMeta_reg <= 1'b0;
      deemphSync_reg <= 1'b0;
    end
    else
    begin
      subcodeMeta_reg <= subcodeStreamPin;
      subcodeSync_reg <= subcodeMeta_reg;
      deemphMeta_reg <= deemphasisPin;
      deemphSync_reg <= deemphMeta_reg;
    end
  end

  // ==========================================================
  // address decoding
  function automatic logic isReg(input logic [ADDR_W-1:0] addr, input logic [3:0] idx);
    isReg = (addr[ADDR_W-1:ADDR_LSB] == {2'h0, idx}) && (addr[ADDR_LSB-1:0] == 2'h0);
  endfunction

  wire accessCycle = psel && penable && !pready_reg;
  wire commit = psel && penable && pready_reg;
  wire [3:0] regIdx = paddr[ADDR_LSB+3:ADDR_LSB];
  wire inRange = (paddr[ADDR_W-1:ADDR_LSB+4] == 2'h0) && (paddr[ADDR_LSB-1:0] == 2'h0);
  wire mainBank = (bankCfg_reg[BANK_SEL_LSB+:2] == BANK_MAIN);
  // bank register stays reachable so software can return to the main bank
  wire hitBank = isReg(paddr, SUBCODE_BANK_SELECT_IDX);
  wire hitPin = mainBank && isReg(paddr, VERSATILE_PIN_CONFIG_IDX);
  wire hitMotor = mainBank && isReg(paddr, MOTOR_SPEED_FEATURE_CTRL_IDX);
  // any other aligned index while a shadow bank is open goes to that bank
  wire hitShadow = !mainBank && inRange && !hitBank;
  wire hitAny = hitBank || hitPin || hitMotor || hitShadow;
  wire doWrite = commit && pwrite;

  // ==========================================================
  // next register values: a write replaces all four bits
  assign pinCfg_next = (doWrite && hitPin) ? pwdata[REG_W-1:0] : pinCfg_reg;
  assign motorCtrl_next = (doWrite && hitMotor) ? pwdata[REG_W-1:0] : motorCtrl_reg;
  assign bankCfg_next = (doWrite && hitBank) ? pwdata[REG_W-1:0] : bankCfg_reg;

  // read mux; shadow contents live outside and read as zero here
  wire [REG_W-1:0] readSel =
    hitPin ? pinCfg_reg :
    hitMotor ? motorCtrl_reg :
    hitBank ? bankCfg_reg : 4'h0;

  // pin word; reset leaves both pins driving high
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pinCfg_reg <= VERSATILE_PIN_CONFIG_RST;
    end
    else
    begin
      pinCfg_reg <= pinCfg_next;
    end
  end

  // motor word; reset keeps twelve percent brake and only the audio features on
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      motorCtrl_reg <= MOTOR_SPEED_FEATURE_CTRL_RST;
    end
    else
    begin
      motorCtrl_reg <= motorCtrl_next;
    end
  end

  // bank word; reset opens the main registers with subcode off
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      bankCfg_reg <= SUBCODE_BANK_SELECT_RST;
    end
    else
    begin
      bankCfg_reg <= bankCfg_next;
    end
  end

  // ==========================================================
  // apb answer: one wait state, then pready with data and error
  // answer values formed here so the flops below stay one-liners
  wire [31:0] readWord = {28'h000_0000, readSel};
  wire readNow = accessCycle && !pwrite;
  wire errNow = accessCycle && !hitAny;

  // ready pulse; its own high level blocks a second commit in one transfer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pready_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= accessCycle;
    end
  end

  // read data stands only with pready, zero otherwise
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      prdata_reg <= readNow ? readWord : 32'h0000_0000;
    end
  end

  // error flag for addresses that no bank claims
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pslverr_reg <= errNow;
    end
  end

  // ==========================================================
  // a shadow write is a committed aligned in-range write, other than the bank word, while a shadow bank is open
  wire shadowCommit = doWrite && hitShadow;

  // shadow bank write strobe, raised at the commit edge for one cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      shadowWrite <= 1'b0;
      shadowIndex <= 4'h0;
      shadowData <= 4'h0;
    end
    else
    begin
      shadowWrite <= shadowCommit;
      shadowIndex <= shadowCommit ? regIdx : shadowIndex;
      shadowData <= shadowCommit ? pwdata[REG_W-1:0] : shadowData;
    end
  end

  // ==========================================================
  // versatile pin drive
  wire fourLine = (pinCfg_reg == FOUR_LINE_MOTOR_CODE);
  wire [1:0] motorLines = {motorLineB, motorLineA};
  wire [1:0] pinSignal = {deemphSync_reg, subcodeSync_reg};
  wire [3:0] pinModes = pinCfg_reg;
  logic [1:0] pinOutNext;
  logic [1:0] pinOeNext;

  // one slice per pin; a field of 00 outside motor mode floats the pin
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pin
      wire dcr_pin_mode_t mode = dcr_pin_mode_t'(pinModes[2*gi+1:2*gi]);
      assign pinOutNext[gi] = fourLine ? motorLines[gi] :
        (mode == PIN_SIGNAL) ? pinSignal[gi] :
        (mode == PIN_HIGH);
      assign pinOeNext[gi] = !(fourLine || (mode != PIN_OFF)); // low while driving
    end
  endgenerate

  // filter is bypassed only while pin five carries the flag
  wire bypassNext = !fourLine && (pinCfg_reg[PIN_FIVE_LSB+:2] == PIN_SIGNAL);

  // pin levels and enables leave through flip-flops
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      versatilePinOut <= PIN_OUT_RST;
      versatilePinOe <= PIN_OE_RST;
    end
    else
    begin
      versatilePinOut <= pinOutNext;
      versatilePinOe <= pinOeNext;
    end
  end

  // bypass flag; off under reset because both pins then drive high
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      deemphasisBypass <= 1'b0;
    end
    else
    begin
      deemphasisBypass <= bypassNext;
    end
  end

  // motor controls; copies of the next values keep outputs flopped with no extra lag
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      brakeSixPct <= MOTOR_SPEED_FEATURE_CTRL_RST[BRAKE_SIX_BIT];
      lockToDisc <= MOTOR_SPEED_FEATURE_CTRL_RST[LOCK_DISC_BIT];
      audioFeatures <= MOTOR_SPEED_FEATURE_CTRL_RST[AUDIO_FEAT_BIT];
      quadSpeed <= MOTOR_SPEED_FEATURE_CTRL_RST[QUAD_SPEED_BIT];
    end
    else
    begin
      brakeSixPct <= motorCtrl_next[BRAKE_SIX_BIT];
      lockToDisc <= motorCtrl_next[LOCK_DISC_BIT];
      audioFeatures <= motorCtrl_next[AUDIO_FEAT_BIT];
      quadSpeed <= motorCtrl_next[QUAD_SPEED_BIT];
    end
  end

  // subcode and bank controls follow the bank word at the commit edge
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      subcodeOn <= SUBCODE_BANK_SELECT_RST[SUBCODE_ON_BIT];
      subcodeThreeWire <= SUBCODE_BANK_SELECT_RST[SUBCODE_THREE_BIT];
      shadowBankSel <= SUBCODE_BANK_SELECT_RST[BANK_SEL_LSB+:2];
    end
    else
    begin
      subcodeOn <= bankCfg_next[SUBCODE_ON_BIT];
      subcodeThreeWire <= bankCfg_next[SUBCODE_THREE_BIT];
      shadowBankSel <= bankCfg_next[BANK_SEL_LSB+:2];
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule // dcr_regs
`default_nettype wire

// [tb/dcr_regs_properties.sv]
// concurrent checks on the decoder control register bank ports
`timescale 1ns/1ns
`default_nettype none
module dcr_regs_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dcr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic motorLineA,
  input wire logic motorLineB,
  input wire logic [1:0] versatilePinOut,
  input wire logic [1:0] versatilePinOe,
  input wire logic deemphasisBypass,
  input wire logic brakeSixPct,
  input wire logic lockToDisc,
  input wire logic audioFeatures,
  input wire logic quadSpeed,
  input wire logic subcodeOn,
  input wire logic subcodeThreeWire,
  input wire logic [1:0] shadowBankSel,
  input wire logic shadowWrite,
  input wire logic [3:0] shadowIndex
);
  import dcr_pkg::*;
  // ==========
  // committed writes split by target; pin outputs lag one edge more
  wire wr = psel && penable && pready && pwrite;
  wire main = shadowBankSel == 2'h0;
  wire wrPin = wr && main && paddr == 8'h34;
  wire [3:0] wd = pwdata[3:0];
  wire [3:0] idx = paddr[5:2];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_motor;
    wr && main && paddr == 8'h38 |=>
      {quadSpeed, audioFeatures, lockToDisc, brakeSixPct} == $past(wd);
  endproperty
  a_motor: assert property (p_motor) else $error("motor controls differ");
  property p_bank;
    wr && paddr == 8'h3C |=> {subcodeThreeWire, subcodeOn, shadowBankSel} == $past(wd);
  endproperty
  a_bank: assert property (p_bank) else $error("bank controls differ");
  property p_four;
    wrPin && wd == 4'h0 |=> ##1
      versatilePinOe == 2'b00 && versatilePinOut == {$past(motorLineB), $past(motorLineA)};
  endproperty
  a_four: assert property (p_four) else $error("four-line motor pins wrong");
  property p_low;
    wrPin && wd[1:0] == 2'b10 |=> ##1 !versatilePinOut[0] && !versatilePinOe[0];
  endproperty
  a_low: assert property (p_low) else $error("pin four not driven low");
  property p_deemph;
    wrPin && wd[3:2] == 2'b01 |=> ##1 deemphasisBypass && !versatilePinOe[1];
  endproperty
  a_deemph: assert property (p_deemph) else $error("de-emphasis bypass missing");
  property p_noshadow;
    wr && main |=> !shadowWrite;
  endproperty
  a_noshadow: assert property (p_noshadow) else $error("shadow strobe in main mode");
  property p_shadow;
    wr && !main && paddr != 8'h3C |=> shadowWrite && shadowIndex == $past(idx);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow write missing");
  property p_pinkept;
    wr && !main && paddr == 8'h34 |=> ##1 $stable(versatilePinOe);
  endproperty
  a_pinkept: assert property (p_pinkept) else $error("pin register hit in shadow");
endmodule // dcr_regs_properties
bind dcr_regs dcr_regs_properties i_props (.sys_clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .motorLineA, .motorLineB, .versatilePinOut, .versatilePinOe,
  .deemphasisBypass, .brakeSixPct, .lockToDisc, .audioFeatures, .quadSpeed, .subcodeOn,
  .subcodeThreeWire, .shadowBankSel, .shadowWrite, .shadowIndex);
`default_nettype wire

// [tb/dcr_host_model.sv]
// apb master standing in for the system microcontroller
`timescale 1ns/1ns
`default_nettype none
module dcr_host_model (
  input wire logic sys_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ==========
  // idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one transfer; released lines carry junk so stale values never match
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err, output logic ok);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    ok = pready === 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // dcr_host_model
`default_nettype wire

// [tb/tb_decoder_control_regs_def.sv]
// self-checking bench for the decoder control register bank
`timescale 1ns/1ns
`default_nettype none
module tb_decoder_control_regs_def;
  import dcr_pkg::*;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, ok;
  logic motorLineA, motorLineB, subcodeStreamPin, deemphasisPin, deemphasisBypass;
  logic brakeSixPct, lockToDisc, audioFeatures, quadSpeed, subcodeOn, subcodeThreeWire;
  logic shadowWrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] versatilePinOut, versatilePinOe, shadowBankSel;
  logic [3:0] shadowIndex, shadowData;
  int errors, samplesChecked, pinReg, motReg, bnkReg, v;
  // ==========
  dcr_regs i_dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .motorLineA, .motorLineB, .subcodeStreamPin, .deemphasisPin,
    .versatilePinOut, .versatilePinOe, .deemphasisBypass, .brakeSixPct, .lockToDisc,
    .audioFeatures, .quadSpeed, .subcodeOn, .subcodeThreeWire, .shadowBankSel,
    .shadowWrite, .shadowIndex, .shadowData);
  dcr_host_model i_host (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  // 25 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // one bus cycle; a missing answer ends the run
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic eErr, input int eRd);
    i_host.xfer(w, a, d, rd, err, ok);
    chk("answer", ok, 1);
    if (!ok)
      tally_and_finish();
    chk("pslverr", err, eErr);
    if (!w)
      chk("prdata", rd, eRd);
    @(negedge sys_clk);
  endtask
  // {float, level} of a pin for a field value
  function automatic logic [1:0] pinExp(input int f, input logic sig);
    return f == 0 ? 2'b10 : f == 1 ? {1'b0, sig} : {1'b0, f == 3};
  endfunction
  // new random pin inputs, held long enough to pass the synchronisers
  task automatic settle();
    logic [1:0] e4, e5;
    @(posedge sys_clk);
    motorLineA <= 1'($urandom);
    motorLineB <= 1'($urandom);
    subcodeStreamPin <= 1'($urandom);
    deemphasisPin <= 1'($urandom);
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    e4 = pinReg == 0 ? {1'b0, motorLineA} : pinExp(pinReg & 3, subcodeStreamPin);
    e5 = pinReg == 0 ? {1'b0, motorLineB} : pinExp(pinReg >> 2, deemphasisPin);
    chk("pin out", versatilePinOut, {e5[0], e4[0]});
    chk("pin oe", versatilePinOe, {e5[1], e4[1]});
    chk("bypass", deemphasisBypass, pinReg >> 2 == 1);
    chk("motor", {quadSpeed, audioFeatures, lockToDisc, brakeSixPct}, motReg);
    chk("bank", {subcodeThreeWire, subcodeOn, shadowBankSel}, bnkReg);
  endtask
  // main sequence
  initial
  begin
    {errors, samplesChecked, pinReg, motReg, bnkReg} = {32'd0, 32'd0, 32'd15, 32'd4, 32'd0};
    {rst_n, motorLineA, motorLineB, subcodeStreamPin, deemphasisPin} = 5'h0;
    v = $urandom(32'h8A4F722E);
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    settle();
    $display("test reset done");
    for (int p = 0; p < 16; p++)
    begin
      pinReg = p;
      acc(1'b1, 8'h34, {28'($urandom), 4'(p)}, 1'b0, 0);
      settle();
      acc(1'b0, 8'h34, 32'h0, 1'b0, pinReg);
    end
    $display("test pins done");
    repeat (8)
    begin
      motReg = $urandom % 16;
      acc(1'b1, 8'h38, 32'(motReg), 1'b0, 0);
      acc(1'b0, 8'h38, 32'h0, 1'b0, motReg);
      settle();
    end
    $display("test motor done");
    for (int b = 1; b < 5; b++)
    begin
      bnkReg = (b % 4) | (int'($urandom % 4) << 2);
      acc(1'b1, 8'h3C, 32'(bnkReg), 1'b0, 0);
      settle();
      if (b < 4)
      begin
        v = $urandom % 15;
        acc(1'b1, 8'(v * 4), 32'(v + 3), 1'b0, 0);
        chk("shadow strobe", shadowWrite, 1);
        chk("shadow index", shadowIndex, v);
        chk("shadow data", shadowData, (v + 3) % 16);
        acc(1'b0, 8'h34, 32'h0, 1'b0, 0);
        acc(1'b1, 8'h34, 32'h0, 1'b0, 0);
        settle();
      end
    end
    acc(1'b1, 8'h20, 32'h5, 1'b1, 0);
    acc(1'b0, 8'h20, 32'h0, 1'b1, 0);
    settle();
    $display("test banks done");
    tally_and_finish();
  end
endmodule // tb_decoder_control_regs_def
`default_nettype wire
